//--- cpu_incdec_regs.svh
`ifndef CPU_INCDEC_REGS_SVH
`define CPU_INCDEC_REGS_SVH

// bit positions of the high latch that feed pc<12:11>
`define HIGH_LATCH_SEL_HI 4
`define HIGH_LATCH_SEL_LO 3
// low pc field loaded by a jump, bits 10..0
`define PC_LOW_HI 10
// reset values
`define ACC_RESET  8'h00
`define PC_RESET   13'h0000
`define ZERO_RESET 1'b0

`endif

//--- cpu_incdec_pkg.sv
package cpu_incdec_pkg;

  typedef enum logic [2:0] {
    op_none = 3'h0,
    op_decrement_skip_on_null = 3'h1,
    op_increment_skip_on_null = 3'h2,
    op_increment_register = 3'h3,
    op_jump_absolute = 3'h4,
    op_or_literal_into_acc = 3'h5,
    op_or_acc_with_register = 3'h6
  } opcode_t;

  // one decoded instruction from the fetch stage
  typedef struct packed {
    logic        valid;
    opcode_t     op;
    logic        to_register;   // target select: 0 accumulator, 1 register
    logic [6:0]  reg_addr;
    logic [10:0] immediate;     // jump target or literal in low 8 bits
  } instr_t;

  // write back to the register file
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [1:0] {
    st_run   = 2'h1,
    st_flush = 2'h2
  } state_t;

endpackage

//--- cpu_alu_unit.sv
`timescale 1ns/1ps
// combinational result and zero detect for the group
module cpu_alu_unit (
  // operands
  input  wire cpu_incdec_pkg::opcode_t op,
  input  wire logic [7:0]              acc,
  input  wire logic [7:0]              reg_value,
  input  wire logic [7:0]              literal,
  // result
  output logic [7:0]                   result,
  output logic                         result_zero
);

  wire [7:0] plus_one  = reg_value + 8'h01;
  wire [7:0] minus_one = reg_value - 8'h01;
  wire [7:0] or_reg    = acc | reg_value;
  wire [7:0] or_lit    = acc | literal;

  // result selection by operation
  assign result = (op == cpu_incdec_pkg::op_decrement_skip_on_null) ? minus_one :
                  (op == cpu_incdec_pkg::op_or_literal_into_acc)    ? or_lit :
                  (op == cpu_incdec_pkg::op_or_acc_with_register)   ? or_reg :
                  plus_one;
  assign result_zero = (result == 8'h00);

endmodule

//--- cpu_incdec_skip_jump_or_ops.sv
`timescale 1ns/1ps
`include "cpu_incdec_regs.svh"
// Operation
// - decrement-skip: f-1 to acc or register, no flags
// - zero decrement result discards next instruction
// - increment: f+1 to acc or register
// - zero increment-skip result discards next instruction
// - jump loads eleven-bit target into pc<10:0>
// - jump copies high latch bits 4:3 to pc<12:11>
// - jump always takes two cycles
// - or-literal: acc|k to acc, zero flag updated
// - or-register: acc|f to acc or register
module cpu_incdec_skip_jump_or_ops (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // decoded instruction and operands
  input  wire cpu_incdec_pkg::instr_t     instr,
  input  wire logic [7:0]                 reg_value,
  input  wire logic [7:0]                 program_counter_high_latch,
  input  wire logic [12:0]                pc_next_seq,
  // architectural results
  output logic [7:0]                      acc,
  output logic                            zero_flag,
  output cpu_incdec_pkg::reg_write_t      reg_write,
  output logic [12:0]                     pc,
  output logic                            pc_load,
  output logic                            busy
);

  // limitation: reg_value must already show a write that reg_write carries
  // in the same cycle; the block has no bypass of its own, so the register
  // file in front of it is expected to forward that write
  cpu_incdec_pkg::state_t state;
  wire [7:0] result;
  wire       result_zero;

  cpu_alu_unit alu (
    .op          (instr.op),
    .acc         (acc),
    .reg_value   (reg_value),
    .literal     (instr.immediate[7:0]),
    .result      (result),
    .result_zero (result_zero)
  );

  // decode one opcode of a valid instruction; every decode wire below shares it
  function automatic logic op_is(input cpu_incdec_pkg::instr_t i,
                                 input cpu_incdec_pkg::opcode_t want);
    op_is = i.valid && (i.op == want);
  endfunction

  // an instruction executes only in run state; the slot after a skip or jump is a nop
  wire exec     = instr.valid && (state == cpu_incdec_pkg::st_run);
  wire is_dec   = exec && op_is(instr, cpu_incdec_pkg::op_decrement_skip_on_null);
  wire is_incs  = exec && op_is(instr, cpu_incdec_pkg::op_increment_skip_on_null);
  wire is_inc   = exec && op_is(instr, cpu_incdec_pkg::op_increment_register);
  wire is_jump  = exec && op_is(instr, cpu_incdec_pkg::op_jump_absolute);
  wire is_orl   = exec && op_is(instr, cpu_incdec_pkg::op_or_literal_into_acc);
  wire is_orw   = exec && op_is(instr, cpu_incdec_pkg::op_or_acc_with_register);
  wire file_op  = is_dec || is_incs || is_inc || is_orw;
  wire to_acc   = (file_op && !instr.to_register) || is_orl;
  wire to_reg   = file_op && instr.to_register;
  wire skip     = (is_dec || is_incs) && result_zero;
  wire sets_z   = is_inc || is_orw || is_orl;
  wire [12:0] jump_target = {program_counter_high_latch[`HIGH_LATCH_SEL_HI:`HIGH_LATCH_SEL_LO],
                             instr.immediate[`PC_LOW_HI:0]};

  cpu_incdec_pkg::state_t next_state;
  assign next_state = (skip || is_jump) ? cpu_incdec_pkg::st_flush
                                        : cpu_incdec_pkg::st_run;

  // state: one flush cycle after a taken skip or a jump
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= cpu_incdec_pkg::st_run;
    end else begin
      state <= next_state;
    end
  end

  // accumulator and zero flag; skip variants leave the flag alone
  always_ff @(posedge clock) begin
    if (rst) begin
      acc       <= `ACC_RESET;
      zero_flag <= `ZERO_RESET;
    end else begin
      if (to_acc) acc <= result;
      if (sets_z) zero_flag <= result_zero;
    end
  end

  // register write-back and program counter outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_write <= '0;
      pc        <= `PC_RESET;
      pc_load   <= 1'b0;
      busy      <= 1'b0;
    end else begin
      reg_write.write <= to_reg;
      reg_write.addr  <= instr.reg_addr;
      reg_write.data  <= result;
      pc_load         <= is_jump;
      pc              <= is_jump ? jump_target : pc_next_seq;
      busy            <= skip || is_jump;
    end
  end

  // checks
  a_dec_skip_flush: assert property (@(posedge clock) disable iff (rst)
    is_dec && reg_value == 8'h01 |=> state == cpu_incdec_pkg::st_flush ##1 state == cpu_incdec_pkg::st_run)
    else $error("decrement skip did not flush one slot");
  a_inc_skip_flush: assert property (@(posedge clock) disable iff (rst)
    is_incs && reg_value == 8'hff |=> busy && state == cpu_incdec_pkg::st_flush)
    else $error("increment skip did not stall");
  a_dec_value: assert property (@(posedge clock) disable iff (rst)
    is_dec && !instr.to_register |=> acc == $past(reg_value) - 8'h01)
    else $error("decrement result wrong");
  a_skip_no_flag: assert property (@(posedge clock) disable iff (rst)
    (is_dec || is_incs) |=> $stable(zero_flag))
    else $error("skip instruction changed zero flag");
  a_jump_target: assert property (@(posedge clock) disable iff (rst)
    is_jump |=> pc_load && pc[10:0] == $past(instr.immediate))
    else $error("jump low bits wrong");
  a_jump_high: assert property (@(posedge clock) disable iff (rst)
    is_jump |=> pc[12:11] == $past(program_counter_high_latch[4:3]))
    else $error("jump high bits wrong");
  a_jump_two: assert property (@(posedge clock) disable iff (rst)
    is_jump |=> !exec ##1 state == cpu_incdec_pkg::st_run)
    else $error("jump not two cycles");
  a_orl_value: assert property (@(posedge clock) disable iff (rst)
    is_orl |=> acc == ($past(acc) | $past(instr.immediate[7:0])) && zero_flag == (acc == 8'h00))
    else $error("or literal wrong");
  a_orw_reg: assert property (@(posedge clock) disable iff (rst)
    is_orw && instr.to_register |=> reg_write.write && reg_write.data == ($past(acc) | $past(reg_value)))
    else $error("or register write wrong");
  a_inc_single: assert property (@(posedge clock) disable iff (rst)
    is_inc |=> state == cpu_incdec_pkg::st_run && zero_flag == (($past(reg_value) + 8'h01) == 8'h00))
    else $error("increment zero flag wrong");
  a_orw_zero: assert property (@(posedge clock) disable iff (rst)
    is_orw |=> !busy && zero_flag == (($past(acc) | $past(reg_value)) == 8'h00))
    else $error("or register zero flag wrong");
  a_inc_go_single: assert property (@(posedge clock) disable iff (rst)
    is_inc |=> !busy)
    else $error("increment stalled");

  // values: checked against the operands, not against the alu output
  a_inc_value: assert property (@(posedge clock) disable iff (rst)
    is_inc && !instr.to_register |=> acc == $past(reg_value) + 8'h01)
    else $error("increment result wrong");
  a_incs_acc: assert property (@(posedge clock) disable iff (rst)
    is_incs && !instr.to_register |=> acc == $past(reg_value) + 8'h01)
    else $error("increment skip result wrong");
  a_incs_reg: assert property (@(posedge clock) disable iff (rst)
    is_incs && instr.to_register |=> reg_write.write && reg_write.data == $past(reg_value) + 8'h01)
    else $error("increment skip write wrong");
  a_dec_reg: assert property (@(posedge clock) disable iff (rst)
    is_dec && instr.to_register |=> reg_write.write && reg_write.data == $past(reg_value) - 8'h01)
    else $error("decrement write wrong");
  a_dec_acc_keep: assert property (@(posedge clock) disable iff (rst)
    is_dec && instr.to_register |=> $stable(acc))
    else $error("decrement to register changed acc");
  a_orw_acc: assert property (@(posedge clock) disable iff (rst)
    is_orw && !instr.to_register |=> acc == ($past(acc) | $past(reg_value)))
    else $error("or register acc wrong");
  a_orw_acc_keep: assert property (@(posedge clock) disable iff (rst)
    is_orw && instr.to_register |=> $stable(acc))
    else $error("or to register changed acc");
  a_write_target: assert property (@(posedge clock) disable iff (rst)
    (is_dec || is_incs || is_inc || is_orw) && instr.to_register
    |=> reg_write.addr == $past(instr.reg_addr))
    else $error("write address wrong");
  a_acc_no_write: assert property (@(posedge clock) disable iff (rst)
    (is_dec || is_incs || is_inc || is_orw) && !instr.to_register |=> !reg_write.write)
    else $error("acc target wrote register");

  // skips that are not taken let the next slot run
  a_dec_go_on: assert property (@(posedge clock) disable iff (rst)
    is_dec && reg_value != 8'h01 |=> !busy && state == cpu_incdec_pkg::st_run)
    else $error("decrement skipped on nonzero");
  a_incs_go_on: assert property (@(posedge clock) disable iff (rst)
    is_incs && reg_value != 8'hff |=> !busy && state == cpu_incdec_pkg::st_run)
    else $error("increment skipped on nonzero");

  // the flushed slot must not write a register, load the pc, or change acc or the zero flag
  a_flush_quiet: assert property (@(posedge clock) disable iff (rst)
    state == cpu_incdec_pkg::st_flush
    |=> !reg_write.write && !pc_load && $stable(acc) && $stable(zero_flag))
    else $error("flushed slot had an effect");
  a_busy_one: assert property (@(posedge clock) disable iff (rst)
    busy |=> !busy)
    else $error("busy held two cycles");

  // jump and literal side effects
  a_jump_no_flag: assert property (@(posedge clock) disable iff (rst)
    is_jump |=> $stable(zero_flag) && $stable(acc) && !reg_write.write)
    else $error("jump changed data state");
  a_pc_follow: assert property (@(posedge clock) disable iff (rst)
    !is_jump |=> !pc_load && pc == $past(pc_next_seq))
    else $error("pc not sequential");
  a_orl_no_write: assert property (@(posedge clock) disable iff (rst)
    is_orl |=> !reg_write.write && !busy)
    else $error("or literal wrote register");

  // reset drives every output to its idle value; no disable here on purpose
  a_reset_clear: assert property (@(posedge clock)
    rst |=> acc == 8'h00 && !zero_flag && !busy && !pc_load && !reg_write.write && pc == 13'h0000)
    else $error("reset values wrong");

  c_dec_skip: cover property (@(posedge clock) disable iff (rst) is_dec && result_zero);
  c_inc_skip: cover property (@(posedge clock) disable iff (rst) is_incs && result_zero);
  c_jump:     cover property (@(posedge clock) disable iff (rst) is_jump);
  c_orw_reg:  cover property (@(posedge clock) disable iff (rst) is_orw && instr.to_register);
  c_orl_zero: cover property (@(posedge clock) disable iff (rst) is_orl && result_zero);

endmodule

//--- cpu_core_partner.sv
`timescale 1ns/1ps
// register file and fetch stage facing the block
module cpu_core_partner (
  // clock
  input  wire logic                       clock,
  // block side
  input  wire logic [6:0]                 reg_addr,
  input  wire cpu_incdec_pkg::reg_write_t reg_write,
  input  wire logic [12:0]                pc,
  output logic [7:0]                      reg_value,
  output logic [12:0]                     pc_next_seq
);
  logic [7:0] mem [128];
  logic       hit;
  // forward a write in flight, else back to back ops on one address read stale data
  assign hit = reg_write.write && (reg_write.addr == reg_addr);
  assign reg_value = hit ? reg_write.data : mem[reg_addr];
  assign pc_next_seq = pc + 13'h0001;
  // write back lands one edge after the block shows it
  // plain always: the bench preloads mem through the hierarchy at time zero
  always @(posedge clock) begin
    if (reg_write.write) begin
      mem[reg_write.addr] <= reg_write.data;
    end
  end
endmodule

//--- cpu_incdec_skip_jump_or_ops_tb_top.sv
`timescale 1ns/1ps
module cpu_incdec_skip_jump_or_ops_tb_top;
  typedef struct packed {
    logic [7:0]                 acc;
    logic                       zero;
    cpu_incdec_pkg::reg_write_t wr;
    logic                       ld;
    logic [12:0]                pc;
    logic                       busy;
  } note_t;
  logic clock, rst, zero_flag, pc_load, busy, e_zero, flush, armed;
  logic [7:0] latch, acc, reg_value, e_acc;
  logic [12:0] pc, pc_next_seq;
  logic [7:0] m [128];
  cpu_incdec_pkg::instr_t instr;
  cpu_incdec_pkg::reg_write_t reg_write;
  note_t q[$];
  note_t mon;
  int errors, cmp_count;
  cpu_incdec_skip_jump_or_ops cpu_incdec_skip_jump_or_ops_inst (.clock(clock), .rst(rst),
    .instr(instr), .reg_value(reg_value), .program_counter_high_latch(latch),
    .pc_next_seq(pc_next_seq), .acc(acc), .zero_flag(zero_flag), .reg_write(reg_write),
    .pc(pc), .pc_load(pc_load), .busy(busy));
  cpu_core_partner cpu_core_partner_inst (.clock(clock), .reg_addr(instr.reg_addr),
    .reg_write(reg_write), .pc(pc), .reg_value(reg_value), .pc_next_seq(pc_next_seq));
  always #20 clock = ~clock;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // drive one instruction and note what the edge after it must show
  task automatic issue(input cpu_incdec_pkg::opcode_t op);
    note_t n;
    logic [7:0] r, lat;
    logic [6:0] a;
    logic d;
    logic [10:0] k;
    a = 7'($urandom_range(0, 15));
    d = 1'($urandom);
    k = 11'($urandom);
    lat = 8'($urandom);
    n = '0;
    r = (op == cpu_incdec_pkg::op_decrement_skip_on_null) ? m[a] - 8'h01 :
        (op == cpu_incdec_pkg::op_or_literal_into_acc) ? (e_acc | k[7:0]) :
        (op == cpu_incdec_pkg::op_or_acc_with_register) ? (e_acc | m[a]) : m[a] + 8'h01;
    if (flush) begin
      flush = 1'b0; // discarded slot shows nothing
    end else if (op == cpu_incdec_pkg::op_jump_absolute) begin
      n.ld = 1'b1;
      n.pc = {lat[4:3], k};
      n.busy = 1'b1;
      flush = 1'b1;
    end else begin
      if (d && op != cpu_incdec_pkg::op_or_literal_into_acc) begin
        n.wr = '{1'b1, a, r};
        m[a] = r;
      end else e_acc = r;
      if (op >= cpu_incdec_pkg::op_increment_register) e_zero = (r == 8'h00);
      else if (r == 8'h00) begin
        n.busy = 1'b1;
        flush = 1'b1;
      end
    end
    n.acc = e_acc;
    n.zero = e_zero;
    instr <= '{1'b1, op, d, a, k};
    latch <= lat;
    q.push_back(n);
    @(posedge clock);
  endtask
  // watcher: a note pushed at one edge is due just after the next
  always @(posedge clock) begin
    #1;
    if (armed) begin
      mon = q.pop_front();
      check({8'h00, acc}, {8'h00, mon.acc});
      check({15'h0, zero_flag}, {15'h0, mon.zero});
      if (mon.wr.write) check(reg_write, mon.wr);
      else check({15'h0, reg_write.write}, 16'h0000);
      check({15'h0, busy}, {15'h0, mon.busy});
      check({15'h0, pc_load}, {15'h0, mon.ld});
      if (mon.ld) check({3'h0, pc}, {3'h0, mon.pc});
    end
    armed = (q.size() > 0);
  end
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    instr = '0;
    latch = 8'h00;
    armed = 1'b0;
    e_acc = 8'h00;
    e_zero = 1'b0;
    flush = 1'b0;
    void'($urandom(32'h75b5));
    // low addresses hold values that wrap to zero, so skips really happen
    for (int i = 0; i < 128; i++) begin
      m[i] = (i < 4) ? 8'hff : (i < 8) ? 8'h01 : 8'(i * 37);
      cpu_core_partner_inst.mem[i] = m[i];
    end
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({8'h00, acc}, 16'h0000);
    @(posedge clock);
    repeat (400) issue(cpu_incdec_pkg::opcode_t'($urandom_range(1, 6)));
    instr <= '0;
    repeat (3) @(posedge clock);
    close_out;
  end
  // watchdog, well past the 416 cycles the run needs
  initial begin
    repeat (1000) @(posedge clock);
    errors++;
    close_out;
  end
endmodule
